// *** core/lrxso_top.sv ***
// nine-channel receive system-side output stage with register port and interrupt
`default_nettype none

// Summary of operation
// - Nine channels run side by side, each with its own pair of configuration registers.
// - Single rail format drives decoded data on the first pin, changing only on the active recovered clock edge.
// - The invert bit of configuration one sets the active level of every data rail output.
// - A powered-down channel floats its two pins or drives them low, as the high-impedance select bit says.
// - Dual rail NRZ format drives undecoded NRZ rails, both updated on the active edge.
// - Dual rail RZ format drives undecoded return-to-zero rails, both updated on the active edge.
// - Dual rail sliced format passes the raw sliced rails through without decoding or edge timing.
// - A positive tip pulse with negative ring marks the positive rail, the opposite marks the negative rail.
// - The second pin is the negative rail in dual formats and the multiplex indication in single rail.
// - A three-bit field picks the multiplex indication among eight sources.
// - The multiplex indication updates on the active edge, the recovered clock source on every core cycle, and is always active high.
// - An internal reference clock is made at the T1 or E1 line rate from the core clock.
// - The edge select bit of configuration one picks rising or falling recovered clock edges.
module lrxso_top
   import lrxso_pkg::*;
(
   input wire logic clk,                          // core clock, 200 MHz
   input wire logic arst_n,                       // async reset, active low
   input wire logic [ADDR_W-1:0] reg_addr,        // register address
   input wire logic [DATA_W-1:0] reg_wdata,       // register write data
   input wire logic reg_wr,                       // write strobe
   input wire logic reg_rd,                       // read strobe
   output logic [DATA_W-1:0] reg_rdata,           // read data, cycle after strobe
   input wire lrxso_line_in_type line_in,         // per-channel line-side levels, async
   output logic [NUM_CH-1:0] rx_pos_rail_out,     // data pin, nrz data or positive rail
   output logic [NUM_CH-1:0] rx_pos_rail_oe,      // data pin driven
   output logic [NUM_CH-1:0] rx_neg_rail_out,     // second pin, negative rail or indication
   output logic [NUM_CH-1:0] rx_neg_rail_oe,      // second pin driven
   output logic irq,                              // level interrupt, active high
   output logic internal_line_rate_clock          // reference clock at line rate
);

   // ************************************************************
   // helpers
   // ************************************************************

   // a configuration address, two per channel
   function automatic logic cfg_hit(input logic [ADDR_W-1:0] a);
      return a <= ADDR_CFG_LAST;
   endfunction

   // channel number from a configuration address
   function automatic int cfg_chan(input logic [ADDR_W-1:0] a);
      return int'(a[4:1]);
   endfunction

   // multiplex indication source, never inverted
   function automatic logic mux_pick(input lrxso_mux_type sel, input logic psync, input logic ais,
                                     input logic exz, input logic bpv, input logic los,
                                     input logic rclk, input logic slp, input logic sln);
      logic v;
      v = 1'b0;
      case (sel)
         MUX_PATTERN_SYNC: v = psync;
         MUX_ALARM: v = ais;
         MUX_EXCESS_ZEROS: v = exz;
         MUX_BIPOLAR_VIOL: v = bpv;
         MUX_EXZ_OR_BPV: v = exz | bpv;
         MUX_LOS: v = los;
         MUX_REC_CLOCK: v = rclk;
         MUX_SLICED_XOR: v = slp ^ sln;
         default: v = 1'b0;
      endcase
      return v;
   endfunction

   // ************************************************************
   // input synchronisation and reference clock
   // ************************************************************
   lrxso_state_type q;
   lrxso_state_type d;
   lrxso_line_in_type li;
   logic [$bits(lrxso_line_in_type)-1:0] li_bits;
   logic [NUM_CH-1:0] sliced_pos;
   logic [NUM_CH-1:0] sliced_neg;

   // every line-side level crosses in one bundle
   lrxso_sync #(
      .W($bits(lrxso_line_in_type))
   ) u_sync (
      .clk(clk),
      .arst_n(arst_n),
      .async_in(line_in),
      .sync_out(li_bits)
   );

   assign li = lrxso_line_in_type'(li_bits);

   // differential slicing of the synchronised tip and ring levels
   assign sliced_pos = li.tip & ~li.ring;
   assign sliced_neg = li.ring & ~li.tip;

   lrxso_rate_gen u_rate (
      .clk(clk),
      .arst_n(arst_n),
      .e1_mode(q.e1_mode),
      .line_rate_clock(internal_line_rate_clock)
   );

   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      logic rise;
      logic fall;
      logic act;
      logic inv;
      logic ind;
      lrxso_fmt_type fmt;
      lrxso_mux_type sel;
      logic [8:0] clr;
      rise = 1'b0;
      fall = 1'b0;
      act = 1'b0;
      inv = 1'b0;
      ind = 1'b0;
      fmt = FMT_SINGLE_NRZ;
      sel = MUX_PATTERN_SYNC;
      clr = '0;
      d = q;
      d.rd_data = '0;
      d.clk_prev = li.rec_clk;
      d.los_prev = li.los;

      // register writes
      if (reg_wr) begin
         if (cfg_hit(reg_addr)) begin
            if (reg_addr[0]) begin
               d.cfg1[cfg_chan(reg_addr)] = reg_wdata[7:0];
            end else begin
               d.cfg0[cfg_chan(reg_addr)] = reg_wdata[7:0];
            end
         end else if (reg_addr == ADDR_MASK) begin
            d.mask = reg_wdata[8:0];
         end else if (reg_addr == ADDR_CTRL) begin
            d.e1_mode = reg_wdata[CTRL_E1_BIT];
         end else if (reg_addr == ADDR_STATUS) begin
            clr = reg_wdata[8:0];
         end
      end

      // register reads; unmapped addresses read as zero
      if (reg_rd) begin
         if (cfg_hit(reg_addr)) begin
            d.rd_data = reg_addr[0] ? {8'h00, q.cfg1[cfg_chan(reg_addr)]} : {8'h00, q.cfg0[cfg_chan(reg_addr)]};
         end else if (reg_addr == ADDR_STATUS) begin
            d.rd_data = {7'h00, q.status};
         end else if (reg_addr == ADDR_MASK) begin
            d.rd_data = {7'h00, q.mask};
         end else if (reg_addr == ADDR_CTRL) begin
            d.rd_data = {15'h0000, q.e1_mode};
         end
      end

      // loss of signal onset is sticky; a new onset beats a clear
      d.status = (q.status & ~clr) | (li.los & ~q.los_prev);

      // per-channel output stage
      for (int i = 0; i < NUM_CH; i++) begin
         rise = li.rec_clk[i] & ~q.clk_prev[i];
         fall = ~li.rec_clk[i] & q.clk_prev[i];
         act = q.cfg1[i][CFG1_EDGE_BIT] ? fall : rise;
         inv = q.cfg1[i][CFG1_INV_BIT];
         fmt = lrxso_fmt_type'(q.cfg1[i][CFG1_FMT_LSB +: 2]);
         sel = lrxso_mux_type'(q.cfg1[i][CFG1_SEL_LSB +: 3]);
         ind = mux_pick(sel, li.pat_sync[i], li.ais[i], li.exz[i], li.bpv[i], li.los[i],
                        li.rec_clk[i], sliced_pos[i], sliced_neg[i]);
         if (q.cfg0[i][CFG0_PD_BIT]) begin
            // powered down: low and driven, or released
            d.pos_out[i] = 1'b0;
            d.neg_out[i] = 1'b0;
            d.pos_oe[i] = ~q.cfg0[i][CFG0_HIZ_BIT];
            d.neg_oe[i] = ~q.cfg0[i][CFG0_HIZ_BIT];
         end else begin
            d.pos_oe[i] = 1'b1;
            d.neg_oe[i] = 1'b1;
            case (fmt)
               FMT_SINGLE_NRZ: begin
                  if (act) begin
                     d.pos_out[i] = li.nrz_data[i] ^ inv;
                     d.neg_out[i] = ind;
                  end
                  // a clock shown as an indication cannot wait for its own edge
                  if (sel == MUX_REC_CLOCK) begin
                     d.neg_out[i] = ind;
                  end
               end
               FMT_DUAL_NRZ: begin
                  if (act) begin
                     d.pos_out[i] = li.nrz_pos[i] ^ inv;
                     d.neg_out[i] = li.nrz_neg[i] ^ inv;
                  end
               end
               FMT_DUAL_RZ: begin
                  if (act) begin
                     d.pos_out[i] = li.rz_pos[i] ^ inv;
                     d.neg_out[i] = li.rz_neg[i] ^ inv;
                  end
               end
               FMT_DUAL_SLICED: begin
                  // untimed pass-through, only the sync and one flop of delay
                  d.pos_out[i] = sliced_pos[i] ^ inv;
                  d.neg_out[i] = sliced_neg[i] ^ inv;
               end
               default: begin
                  d.pos_out[i] = 1'b0;
                  d.neg_out[i] = 1'b0;
               end
            endcase
         end
      end
   end

   // ************************************************************
   // state register
   // ************************************************************
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         q.cfg0 <= {NUM_CH{CFG0_RESET}};
         q.cfg1 <= {NUM_CH{CFG1_RESET}};
         q.e1_mode <= CTRL_E1_RESET;
         q.status <= STATUS_RESET;
         q.mask <= MASK_RESET;
         q.clk_prev <= '0;
         q.los_prev <= '0;
         q.pos_out <= '0;
         q.neg_out <= '0;
         q.pos_oe <= '0;
         q.neg_oe <= '0;
         q.rd_data <= '0;
      end else begin
         q <= d;
      end
   end

   // outputs straight from flops, interrupt from status and mask
   assign rx_pos_rail_out = q.pos_out;
   assign rx_neg_rail_out = q.neg_out;
   assign rx_pos_rail_oe = q.pos_oe;
   assign rx_neg_rail_oe = q.neg_oe;
   assign reg_rdata = q.rd_data;
   assign irq = |(q.status & q.mask);

   // ************************************************************
   // checks on channel zero, loss status on channel one, the interrupt and the register port
   // ************************************************************
   logic c0_pd;
   logic c0_hiz;
   logic c0_inv;
   logic c0_edge;
   logic c0_rise;
   logic c0_fall;
   logic [1:0] c0_fmt;
   logic [2:0] c0_sel;

   assign c0_pd = q.cfg0[0][CFG0_PD_BIT];
   assign c0_hiz = q.cfg0[0][CFG0_HIZ_BIT];
   assign c0_inv = q.cfg1[0][CFG1_INV_BIT];
   assign c0_edge = q.cfg1[0][CFG1_EDGE_BIT];
   assign c0_fmt = q.cfg1[0][CFG1_FMT_LSB +: 2];
   assign c0_sel = q.cfg1[0][CFG1_SEL_LSB +: 3];
   assign c0_rise = li.rec_clk[0] & ~q.clk_prev[0];
   assign c0_fall = ~li.rec_clk[0] & q.clk_prev[0];

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   AST_PD_DRIVE_LOW: assert property (c0_pd && !c0_hiz |=>
      rx_pos_rail_oe[0] && rx_neg_rail_oe[0] && !rx_pos_rail_out[0] && !rx_neg_rail_out[0])
      else $error("powered-down channel not driven low");

   AST_PD_RELEASE: assert property (c0_pd && c0_hiz |=> !rx_pos_rail_oe[0] && !rx_neg_rail_oe[0])
      else $error("powered-down channel still driving");

   AST_SINGLE_DATA: assert property (!c0_pd && c0_fmt == 2'(FMT_SINGLE_NRZ) &&
      (c0_edge ? c0_fall : c0_rise) |=> rx_pos_rail_out[0] == ($past(li.nrz_data[0]) ^ $past(c0_inv)))
      else $error("single rail data wrong after active edge");

   AST_SINGLE_HOLD: assert property (!c0_pd && c0_fmt == 2'(FMT_SINGLE_NRZ) &&
      !(c0_edge ? c0_fall : c0_rise) ##1 !c0_pd |-> $stable(rx_pos_rail_out[0]))
      else $error("single rail data moved off the active edge");

   AST_DUAL_NRZ: assert property (!c0_pd && c0_fmt == 2'(FMT_DUAL_NRZ) && (c0_edge ? c0_fall : c0_rise) |=>
      rx_pos_rail_out[0] == ($past(li.nrz_pos[0]) ^ $past(c0_inv)) &&
      rx_neg_rail_out[0] == ($past(li.nrz_neg[0]) ^ $past(c0_inv)))
      else $error("dual rail nrz rails wrong");

   AST_DUAL_RZ: assert property (!c0_pd && c0_fmt == 2'(FMT_DUAL_RZ) && (c0_edge ? c0_fall : c0_rise) |=>
      rx_pos_rail_out[0] == ($past(li.rz_pos[0]) ^ $past(c0_inv)) &&
      rx_neg_rail_out[0] == ($past(li.rz_neg[0]) ^ $past(c0_inv)))
      else $error("dual rail rz rails wrong");

   AST_SLICED_RAILS: assert property (!c0_pd && c0_fmt == 2'(FMT_DUAL_SLICED) && !c0_inv |=>
      rx_pos_rail_out[0] == ($past(li.tip[0]) && !$past(li.ring[0])) &&
      rx_neg_rail_out[0] == ($past(li.ring[0]) && !$past(li.tip[0])))
      else $error("sliced rails do not follow tip and ring");

   AST_SLICED_INVERT: assert property (!c0_pd && c0_fmt == 2'(FMT_DUAL_SLICED) && c0_inv
      ##1 li.tip[0] == li.ring[0] |-> rx_pos_rail_out[0] && rx_neg_rail_out[0] [*1] or
      !($past(li.tip[0]) == $past(li.ring[0])))
      else $error("inverted sliced rails not high when idle");

   AST_MUX_LOS_HIGH: assert property (!c0_pd && c0_fmt == 2'(FMT_SINGLE_NRZ) &&
      c0_sel == 3'(MUX_LOS) && c0_inv && (c0_edge ? c0_fall : c0_rise) |=> rx_neg_rail_out[0] == $past(li.los[0]))
      else $error("indication inverted or late");

   AST_MUX_XOR: assert property (!c0_pd && c0_fmt == 2'(FMT_SINGLE_NRZ) &&
      c0_sel == 3'(MUX_SLICED_XOR) && c0_rise && !c0_edge |=> rx_neg_rail_out[0] == ($past(li.tip[0]) ^ $past(li.ring[0])))
      else $error("sliced xor indication wrong");

   // onset on an enabled channel must reach the pin; a write may move mask or status
   AST_IRQ_LEVEL: assert property ((li.los & ~q.los_prev & q.mask) != 9'h000 && !reg_wr |=> irq)
      else $error("unmasked loss onset without interrupt");

   // channels 1 and 2 are taken into loss, channel 1 is checked; only a clear may drop it again
   AST_LOS_STICKY: assert property (li.los[1] && !q.los_prev[1] |=> q.status[1] ##1
      (q.status[1] || $past(reg_wr && reg_addr == ADDR_STATUS && reg_wdata[1])))
      else $error("loss onset not held in status");

   AST_READ_ONE_CYCLE: assert property (reg_rd && reg_addr == ADDR_CTRL ##1 !reg_rd |=> reg_rdata == 16'h0000)
      else $error("read data held past its cycle");

   COV_SINGLE_EDGE: cover property (!c0_pd && c0_fmt == 2'(FMT_SINGLE_NRZ) && c0_rise ##1 rx_pos_rail_out[0]);
   COV_SLICED: cover property (!c0_pd && c0_fmt == 2'(FMT_DUAL_SLICED) ##1 rx_neg_rail_out[0]);
   COV_PD_HIZ: cover property (c0_pd && c0_hiz ##1 !rx_pos_rail_oe[0]);
   COV_IRQ: cover property (!irq ##1 irq);

endmodule
`default_nettype wire

// *** core/lrxso_pkg.sv ***
// package for the receive system-side output stage: map, fields, rates, types
`default_nettype none
package lrxso_pkg;

   // ************************************************************
   // sizes and register map
   // ************************************************************
   localparam int NUM_CH = 9;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam logic [7:0] ADDR_CFG_LAST = 8'h11; // cfg0 of channel n at 2n, cfg1 at 2n+1
   localparam logic [7:0] ADDR_STATUS = 8'h20;
   localparam logic [7:0] ADDR_MASK = 8'h21;
   localparam logic [7:0] ADDR_CTRL = 8'h22;

   // ************************************************************
   // field positions and reset values
   // ************************************************************
   localparam int CFG0_PD_BIT = 5;
   localparam int CFG0_HIZ_BIT = 6;
   localparam int CFG1_SEL_LSB = 5;
   localparam int CFG1_EDGE_BIT = 4;
   localparam int CFG1_INV_BIT = 3;
   localparam int CFG1_FMT_LSB = 0;
   localparam int CTRL_E1_BIT = 0;
   localparam logic [7:0] CFG0_RESET = 8'h00;
   localparam logic [7:0] CFG1_RESET = 8'h00;
   localparam logic [8:0] MASK_RESET = 9'h000;
   localparam logic [8:0] STATUS_RESET = 9'h000;
   localparam logic CTRL_E1_RESET = 1'h0;

   // ************************************************************
   // line rate generation
   // ************************************************************
   localparam longint unsigned CLK_RATE_KHZ = 200000;
   localparam longint unsigned T1_RATE_KHZ = 1544;
   localparam longint unsigned E1_RATE_KHZ = 2048;
   localparam logic [31:0] T1_PHASE_INC = 32'((T1_RATE_KHZ << 32) / CLK_RATE_KHZ);
   localparam logic [31:0] E1_PHASE_INC = 32'((E1_RATE_KHZ << 32) / CLK_RATE_KHZ);

   // ************************************************************
   // types
   // ************************************************************
   typedef enum logic [1:0] {FMT_SINGLE_NRZ, FMT_DUAL_NRZ, FMT_DUAL_RZ, FMT_DUAL_SLICED} lrxso_fmt_type;
   typedef enum logic [2:0] {MUX_PATTERN_SYNC, MUX_ALARM, MUX_EXCESS_ZEROS, MUX_BIPOLAR_VIOL,
                             MUX_EXZ_OR_BPV, MUX_LOS, MUX_REC_CLOCK, MUX_SLICED_XOR} lrxso_mux_type;

   typedef struct packed {
      logic [8:0] rec_clk;
      logic [8:0] nrz_data;
      logic [8:0] nrz_pos;
      logic [8:0] nrz_neg;
      logic [8:0] rz_pos;
      logic [8:0] rz_neg;
      logic [8:0] tip;
      logic [8:0] ring;
      logic [8:0] pat_sync;
      logic [8:0] ais;
      logic [8:0] exz;
      logic [8:0] bpv;
      logic [8:0] los;
   } lrxso_line_in_type;

   typedef struct packed {
      logic [8:0][7:0] cfg0;
      logic [8:0][7:0] cfg1;
      logic e1_mode;
      logic [8:0] status;
      logic [8:0] mask;
      logic [8:0] clk_prev;
      logic [8:0] los_prev;
      logic [8:0] pos_out;
      logic [8:0] neg_out;
      logic [8:0] pos_oe;
      logic [8:0] neg_oe;
      logic [15:0] rd_data;
   } lrxso_state_type;

endpackage
`default_nettype wire

// *** core/lrxso_sync.sv ***
// two-flop synchroniser for a bundle of asynchronous levels
`default_nettype none
module lrxso_sync
   import lrxso_pkg::*;
#(
   parameter int W = 8
) (
   input wire logic clk,             // core clock
   input wire logic arst_n,          // async reset, active low
   input wire logic [W-1:0] async_in, // levels from another domain
   output logic [W-1:0] sync_out     // levels safe to use
);

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } lrxso_sync_state_type;

   lrxso_sync_state_type q;
   lrxso_sync_state_type d;

   // first stage feeds only the second stage
   always_comb begin
      d.meta = async_in;
      d.stable = q.meta;
   end

   // ************************************************************
   // state register
   // ************************************************************
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign sync_out = q.stable;

endmodule
`default_nettype wire

// *** core/lrxso_rate_gen.sv ***
// phase accumulator making the internal line rate reference clock
`default_nettype none
module lrxso_rate_gen
   import lrxso_pkg::*;
(
   input wire logic clk,            // core clock
   input wire logic arst_n,         // async reset, active low
   input wire logic e1_mode,        // 1 selects the faster line rate
   output logic line_rate_clock     // reference clock, registered
);

   typedef struct packed {
      logic [31:0] acc;
      logic msb_prev;
      logic mode_prev;
      logic [7:0] half_cnt;
      logic cnt_ok;
   } lrxso_rate_state_type;

   lrxso_rate_state_type q;
   lrxso_rate_state_type d;
   logic toggle;

   assign toggle = q.acc[31] != q.msb_prev;

   // accumulate; jitter is one core cycle, a fair trade for no pll
   always_comb begin
      d = q;
      d.acc = q.acc + (e1_mode ? E1_PHASE_INC : T1_PHASE_INC);
      d.msb_prev = q.acc[31];
      d.mode_prev = e1_mode;
      d.half_cnt = toggle ? 8'h01 : ((q.half_cnt == 8'hff) ? q.half_cnt : q.half_cnt + 8'h01);
      if (e1_mode != q.mode_prev) begin
         d.cnt_ok = 1'b0;
      end else if (toggle) begin
         d.cnt_ok = 1'b1;
      end
   end

   // ************************************************************
   // state register
   // ************************************************************
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign line_rate_clock = q.acc[31];

   // ************************************************************
   // checks
   // ************************************************************
   localparam int E1_HALF_MIN = 48;
   localparam int E1_HALF_MAX = 49;
   localparam int T1_HALF_MIN = 64;
   localparam int T1_HALF_MAX = 65;

   AST_RATE_HALF_PERIOD: assert property (@(posedge clk) disable iff (!arst_n)
      toggle && q.cnt_ok && (e1_mode == q.mode_prev) |->
      (e1_mode ? (q.half_cnt >= 8'(E1_HALF_MIN) && q.half_cnt <= 8'(E1_HALF_MAX))
               : (q.half_cnt >= 8'(T1_HALF_MIN) && q.half_cnt <= 8'(T1_HALF_MAX))))
      else $error("line rate half period out of range");

endmodule
`default_nettype wire

// *** testbench/lrxso_framer_model.sv ***
// framer model capturing the output pins on the edge opposite the update edge
`default_nettype none
module lrxso_framer_model (
   input wire logic clk,             // core clock
   input wire logic rec_clk,         // recovered clock as seen on the line side
   input wire logic [8:0] edge_sel,  // per channel update edge, 1 falling
   input wire logic [8:0] pos_in,    // first pin
   input wire logic [8:0] neg_in,    // second pin
   input wire logic [8:0] pos_oe,    // first pin driven
   input wire logic [8:0] neg_oe,    // second pin driven
   output logic [17:0] cap_q         // captured {neg, pos}
);
   timeunit 1ns;
   timeprecision 1ps;
   logic rec_q = 1'b0;
   // capture on the opposite edge, when pins are long settled
   always @(posedge clk) begin
      rec_q <= rec_clk;
      for (int i = 0; i < 9; i++) begin
         if (rec_q != rec_clk && rec_clk == edge_sel[i]) begin
            // a released pin reads as the inverse of its last level
            cap_q[i] <= pos_oe[i] ? pos_in[i] : ~pos_in[i];
            cap_q[i+9] <= neg_oe[i] ? neg_in[i] : ~neg_in[i];
         end
      end
   end
endmodule
`default_nettype wire

// *** testbench/lrxso_top_tb.sv ***
// self-checking bench for the receive output stage
`default_nettype none
module lrxso_top_tb
   import lrxso_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin fail_count++; $display("BAD %s exp %h got %h", n, e, s); end end
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [15:0] reg_rdata, q;
   lrxso_line_in_type line_in = '0, cur = '0, prev = '0;
   logic [8:0] pos, pos_oe, neg, neg_oe, edge_v, ep, en, eo, ef;
   logic [8:0] los_v = 9'h000;
   logic irq, refclk;
   logic [17:0] cap;
   logic [4:0] cnt = 5'h00;
   logic [7:0] cfg0 [9] = '{default: 8'h00};
   logic [7:0] cfg1 [9] = '{default: 8'h00};
   int seed = 32'h944f;
   int fail_count = 0;
   int checks = 0;
   int n;
   always #2.5 clk = ~clk;
   lrxso_top i_dut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .line_in(line_in), .rx_pos_rail_out(pos), .rx_pos_rail_oe(pos_oe),
      .rx_neg_rail_out(neg), .rx_neg_rail_oe(neg_oe), .irq(irq), .internal_line_rate_clock(refclk));
   lrxso_framer_model i_framer (.clk(clk), .rec_clk(line_in.rec_clk[0]), .edge_sel(edge_v), .pos_in(pos),
      .neg_in(neg), .pos_oe(pos_oe), .neg_oe(neg_oe), .cap_q(cap));
   always_comb for (int i = 0; i < 9; i++) edge_v[i] = cfg1[i][4];
   // ************************************************************
   // line side: 125 ns recovered clock, data moved midway between edges
   // ************************************************************
   always @(posedge clk) begin : drive
      lrxso_line_in_type t;
      t = line_in;
      cnt <= (cnt == 5'h18) ? 5'h00 : cnt + 5'h01;
      if (cnt == 5'h05) t = 117'({$random(seed), $random(seed), $random(seed), $random(seed)});
      t.los = los_v;
      t.rec_clk = {9{cnt == 5'h18 || cnt < 5'h0b}};
      if (cnt == 5'h05) begin
         prev <= cur;
         cur <= t;
      end
      line_in <= t;
   end
   // one bus cycle; strobes stand for exactly one edge
   task automatic bus(logic w, logic r, logic [7:0] a, logic [15:0] d);
      reg_wr <= w;
      reg_rd <= r;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
   endtask
   task automatic rd(logic [7:0] a, output logic [15:0] v);
      bus(1'b0, 1'b1, a, 16'h0000);
      #1 v = reg_rdata;
   endtask
   task automatic wait_cnt(logic [4:0] v);
      bus(1'b0, 1'b0, 8'h00, 16'h0000);
      #1;
      while (cnt !== v) begin
         @(posedge clk);
         #1;
      end
   endtask
   task automatic count_ref(output int k);
      logic last;
      k = 0;
      last = refclk;
      bus(1'b0, 1'b0, 8'h00, 16'h0000);
      repeat (5000) begin
         @(posedge clk);
         #1;
         if (refclk && !last) k++;
         last = refclk;
      end
   endtask
   // expected {neg, pos}; d is the data seen at the active edge, s the live data
   function automatic logic [1:0] exp_ch(int i, logic [7:0] c0, logic [7:0] c1, lrxso_line_in_type d,
                                         lrxso_line_in_type s);
      logic p, m;
      logic [7:0] mux;
      mux = {d.tip[i] ^ d.ring[i], 1'b0, d.los[i], d.exz[i] | d.bpv[i], d.bpv[i], d.exz[i], d.ais[i], d.pat_sync[i]};
      case (c1[1:0])
         2'h0: begin p = d.nrz_data[i]; m = mux[c1[7:5]]; end
         2'h1: begin p = d.nrz_pos[i]; m = d.nrz_neg[i]; end
         2'h2: begin p = d.rz_pos[i]; m = d.rz_neg[i]; end
         default: begin p = s.tip[i] & ~s.ring[i]; m = s.ring[i] & ~s.tip[i]; end
      endcase
      p ^= c1[3];
      if (c1[1:0] != 2'h0) m ^= c1[3];
      return c0[5] ? 2'b00 : {m, p};
   endfunction
   task automatic results;
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      #300000;
      fail_count++;
      results;
   end
   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      repeat (4) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      rd(8'h03, q); `CHK("cfg1 reset", 16'h0000, q)
      rd(8'h30, q); `CHK("unmapped read", 16'h0000, q)
      // random per-channel settings; a few channels powered down
      for (int k = 0; k < 40; k++) begin
         for (int i = 0; i < 9; i++) begin
            cfg0[i] = {1'b0, 1'($random(seed)), 1'($random(seed) % 5 == 0), 5'h00};
            cfg1[i] = 8'($random(seed)) & 8'hfb;
            // first rounds walk channel 0 through every indication source, inverted
            if (i == 0 && k < 16) begin
               cfg0[0] = 8'h00;
               cfg1[0] = {3'(k), 1'(k >> 3), 4'h8};
            end
            bus(1'b1, 1'b0, 8'(2 * i), {8'h00, cfg0[i]});
            bus(1'b1, 1'b0, 8'(2 * i + 1), {8'h00, cfg1[i]});
         end
         rd(8'h11, q); `CHK("cfg1 readback", {8'h00, cfg1[8]}, q)
         repeat (3) wait_cnt(5'h18);
         for (int i = 0; i < 9; i++) begin
            {en[i], ep[i]} = exp_ch(i, cfg0[i], cfg1[i], cfg1[i][4] ? cur : prev, cur);
            eo[i] = cfg0[i][5] ? ~cfg0[i][6] : 1'b1;
            // a clock indication is still high at the falling capture
            ef[i] = en[i] | ~eo[i] | (cfg1[i][7:5] == 3'h6 && cfg1[i][1:0] == 2'h0 && !cfg0[i][5]);
         end
         `CHK("first pin", ep, pos)
         `CHK("second pin", en, neg)
         `CHK("first oe", eo, pos_oe)
         `CHK("second oe", eo, neg_oe)
         `CHK("framer capture", {ef, ep | ~eo} & {2{~edge_v}}, cap & {2{~edge_v}})
      end
      // loss of signal onset raises, masks and clears the interrupt
      bus(1'b1, 1'b0, 8'h21, 16'h0004);
      bus(1'b1, 1'b0, 8'h20, 16'h01ff);
      los_v <= 9'h006;
      repeat (5) bus(1'b0, 1'b0, 8'h00, 16'h0000);
      rd(8'h20, q); `CHK("status set", 16'h0006, q)
      `CHK("irq unmasked", 1'b1, irq)
      bus(1'b1, 1'b0, 8'h20, 16'h0004);
      rd(8'h20, q); `CHK("status cleared", 16'h0002, q)
      `CHK("irq masked", 1'b0, irq)
      bus(1'b1, 1'b0, 8'h21, 16'h0002);
      wait_cnt(5'h00); `CHK("irq remasked", 1'b1, irq)
      // reference clock rate in both line modes
      bus(1'b1, 1'b0, 8'h22, 16'h0000);
      rd(8'h22, q); `CHK("ctrl t1", 16'h0000, q)
      count_ref(n); `CHK("t1 rate", 1'b1, (n == 38 || n == 39))
      bus(1'b1, 1'b0, 8'h22, 16'h0001);
      rd(8'h22, q); `CHK("ctrl e1", 16'h0001, q)
      count_ref(n); `CHK("e1 rate", 1'b1, (n == 51 || n == 52))
      results;
   end
endmodule
`default_nettype wire
